// >>> core/bwu_match.sv
// bus watch comparator match logic with an axi4-lite register slave
// assumes a cpu bus that shows one qualified cycle per clk_sys edge
// and opcode tracking that reports the address of an executing tag
`timescale 1ns/10ps
module bwu_match
	import bwu_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// observed cpu bus and opcode tracking
	input  wire bwu_bus_type bus,
	input  wire bwu_tag_type tag,
	// match channels towards sequencer and breakpoint logic
	output logic [2:0]       match,
	output logic [2:0]       brk_req,
	// axi4-lite slave
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [5:0]  s_awaddr,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	output logic             s_bvalid,
	output logic [1:0]       s_bresp,
	input  wire logic        s_bready,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	input  wire logic [5:0]  s_araddr,
	output logic             s_rvalid,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	input  wire logic        s_rready
);
	bwu_state_type s_q;
	bwu_state_type s_d;

	// exact address hit with direction and size qualification
	function automatic logic addr_hit(input logic [ADDR_W-1:0] ref_a,
		input bwu_ctl_type c, input logic use_size, input bwu_bus_type b);
		logic dir_ok;
		logic size_ok;
		dir_ok  = !c.dir_chk || (b.rd == c.dir_sel);
		size_ok = !use_size || !c.size_chk ||
			(b.byte_acc == c.size_sel);
		addr_hit = (b.addr == ref_a) && dir_ok && size_ok;
	endfunction

	// masked data compare, equality or difference
	function automatic logic data_hit(input logic [DATA_W-1:0] ref_d,
		input logic [DATA_W-1:0] msk, input logic inv,
		input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] diff;
		diff = (d ^ ref_d) & msk;
		if (inv) begin
			data_hit = |diff;
		end else begin
			data_hit = ~|diff;
		end
	endfunction

	// register read decode
	function automatic logic [31:0] reg_read(input bwu_state_type s,
		input logic [5:0] a);
		reg_read = 32'h0;
		if (a == OFS_A_ADDR) begin
			reg_read = {14'h0, s.addr_a};
		end else if (a == OFS_B_ADDR) begin
			reg_read = {14'h0, s.addr_b};
		end else if (a == OFS_C_ADDR) begin
			reg_read = {14'h0, s.addr_c};
		end else if (a == OFS_A_DATA) begin
			reg_read = {16'h0, s.data_a};
		end else if (a == OFS_A_MASK) begin
			reg_read = {16'h0, s.mask_a};
		end else if (a == OFS_CTRL) begin
			reg_read = {6'h0, s.range, s.ctl_c, s.ctl_b, s.ctl_a};
		end else if (a == OFS_STAT) begin
			reg_read = {26'h0, s.seen, s.match};
		end
	endfunction

	function automatic logic reg_known(input logic [5:0] a);
		reg_known = (a == OFS_A_ADDR) || (a == OFS_B_ADDR) ||
			(a == OFS_C_ADDR) || (a == OFS_A_DATA) ||
			(a == OFS_A_MASK) || (a == OFS_CTRL) || (a == OFS_STAT);
	endfunction

	// combinational match terms
	logic        quiet;
	logic        mode_rng;
	logic [15:0] bus_data;
	logic        a_f;
	logic        b_f;
	logic        c_f;
	logic        a_t;
	logic        b_t;
	logic        c_t;
	logic        in_f;
	logic        out_f;
	logic        in_t;
	logic        out_t;
	logic        rng_q;
	logic [2:0]  hit;
	logic        wr_go;

	// per comparator forced and tagged hits
	always_comb begin
		quiet    = bus.background_debug_mode;
		mode_rng = s_q.range[1];
		// word: low address byte arrives in data[15:8]; byte in data[7:0]
		bus_data = bus.byte_acc ? {bus.data[7:0], 8'h00} :
			bus.data;
		a_f = bus.valid && !quiet && s_q.ctl_a.enable && !s_q.ctl_a.tag &&
			addr_hit(s_q.addr_a, s_q.ctl_a, 1'b1, bus) &&
			data_hit(s_q.data_a, bus.byte_acc ?
			(s_q.mask_a & 16'hFF00) : s_q.mask_a, s_q.ctl_a.invert,
			bus_data);
		b_f = bus.valid && !quiet && s_q.ctl_b.enable && !s_q.ctl_b.tag &&
			addr_hit(s_q.addr_b, s_q.ctl_b, 1'b1, bus);
		c_f = bus.valid && !quiet && s_q.ctl_c.enable && !s_q.ctl_c.tag &&
			addr_hit(s_q.addr_c, s_q.ctl_c, 1'b0, bus);
		// tagged: only the exact opcode address counts
		a_t = tag.tag_hit && !quiet && s_q.ctl_a.enable && s_q.ctl_a.tag &&
			(tag.tag_addr == s_q.addr_a);
		b_t = tag.tag_hit && !quiet && s_q.ctl_b.enable && s_q.ctl_b.tag &&
			(tag.tag_addr == s_q.addr_b);
		c_t = tag.tag_hit && !quiet && s_q.ctl_c.enable && s_q.ctl_c.tag &&
			(tag.tag_addr == s_q.addr_c);
		// forced range, a's direction and data, no size
		rng_q = bus.valid && !quiet &&
			(!s_q.ctl_a.dir_chk || bus.rd == s_q.ctl_a.dir_sel) &&
			data_hit(s_q.data_a, bus.byte_acc ?
			(s_q.mask_a & 16'hFF00) : s_q.mask_a, s_q.ctl_a.invert,
			bus_data);
		in_f  = rng_q && (s_q.addr_a <= bus.addr) &&
			(bus.addr <= s_q.addr_b);
		out_f = rng_q && ((bus.addr < s_q.addr_a) ||
			(bus.addr > s_q.addr_b));
		// tagged range at word granularity
		in_t  = tag.tag_hit && !quiet &&
			(s_q.addr_a[ADDR_W-1:1] <= tag.tag_addr[ADDR_W-1:1]) &&
			(tag.tag_addr[ADDR_W-1:1] <= s_q.addr_b[ADDR_W-1:1]);
		out_t = tag.tag_hit && !quiet &&
			((tag.tag_addr[ADDR_W-1:1] < s_q.addr_a[ADDR_W-1:1]) ||
			(tag.tag_addr[ADDR_W-1:1] > s_q.addr_b[ADDR_W-1:1]));
		hit = {c_f || c_t, b_f || b_t, a_f || a_t};
		if (mode_rng && s_q.ctl_a.enable) begin
			// a's tag selects forced or tagged range; b is unused
			if (s_q.range == RANGE_INSIDE) begin
				hit[0] = s_q.ctl_a.tag ? in_t : in_f;
			end else begin
				hit[0] = s_q.ctl_a.tag ? out_t : out_f;
			end
			hit[1] = 1'b0;
		end else if (mode_rng) begin
			hit[1:0] = 2'b00;
		end
	end

	assign wr_go = s_q.aw_ok && s_q.w_ok && !s_q.bvalid;

	// next state: matches, register writes and bus handshakes
	always_comb begin
		s_d = s_q;
		// match and break fresh per cycle; only seen keeps hits from older cycles
		s_d.match = hit;
		s_d.breakpoint_request_enable = hit & {s_q.ctl_c.breakpoint_request_enable, s_q.ctl_b.breakpoint_request_enable && !mode_rng,
			s_q.ctl_a.breakpoint_request_enable};
		s_d.seen = s_q.seen | hit;
		if (s_awvalid && s_awready) begin
			s_d.aw_ok   = 1'b1;
			s_d.aw_addr = s_awaddr;
		end
		if (s_wvalid && s_wready) begin
			s_d.w_ok   = 1'b1;
			s_d.w_data = s_wdata;
		end
		if (wr_go) begin
			s_d.aw_ok  = 1'b0;
			s_d.w_ok   = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = reg_known(s_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
			if (s_q.aw_addr == OFS_A_ADDR) begin
				s_d.addr_a = s_q.w_data[ADDR_W-1:0];
			end else if (s_q.aw_addr == OFS_B_ADDR) begin
				s_d.addr_b = s_q.w_data[ADDR_W-1:0];
			end else if (s_q.aw_addr == OFS_C_ADDR) begin
				s_d.addr_c = s_q.w_data[ADDR_W-1:0];
			end else if (s_q.aw_addr == OFS_A_DATA) begin
				s_d.data_a = s_q.w_data[DATA_W-1:0];
			end else if (s_q.aw_addr == OFS_A_MASK) begin
				s_d.mask_a = s_q.w_data[DATA_W-1:0];
			end else if (s_q.aw_addr == OFS_CTRL) begin
				s_d.ctl_a = s_q.w_data[7:0];
				s_d.ctl_b = s_q.w_data[15:8];
				s_d.ctl_c = s_q.w_data[23:16];
				s_d.range = s_q.w_data[25:24];
			end else if (s_q.aw_addr == OFS_STAT) begin
				// write one to clear, new hits win
				s_d.seen = (s_q.seen & ~s_q.w_data[5:3]) | hit;
			end
		end
		if (s_q.bvalid && s_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_arvalid && s_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rdata  = reg_read(s_q, s_araddr);
			s_d.rresp  = reg_known(s_araddr) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_q.rvalid && s_rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// port drive
	assign match     = s_q.match;
	assign brk_req   = s_q.breakpoint_request_enable;
	assign s_awready = !s_q.aw_ok;
	assign s_wready  = !s_q.w_ok;
	assign s_bvalid  = s_q.bvalid;
	assign s_bresp   = s_q.bresp;
	assign s_arready = !s_q.rvalid;
	assign s_rvalid  = s_q.rvalid;
	assign s_rdata   = s_q.rdata;
	assign s_rresp   = s_q.rresp;

	// checks
	sequence bdm_cycle;
		bus.background_debug_mode && !tag.tag_hit;
	endsequence
	a_bdm_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		bus.background_debug_mode |=> match == 3'h0) else $error("match during bdm");
	a_bdm_seq_quiet: assert property (@(posedge clk_sys) disable iff (rst)
		bdm_cycle |-> ##1 (match == 3'h0) ##1 1'b1)
		else $error("match after bdm cycle");
	a_c_exact_addr: assert property (@(posedge clk_sys) disable iff (rst)
		(match[2] && !$past(s_q.ctl_c.tag)) |->
		$past(bus.addr) == $past(s_q.addr_c))
		else $error("c hit on wrong address");
	a_c_direction: assert property (@(posedge clk_sys) disable iff (rst)
		(match[2] && !s_q.ctl_c.tag && s_q.ctl_c.dir_chk &&
		$stable(s_q.ctl_c)) |-> $past(bus.rd) == s_q.ctl_c.dir_sel)
		else $error("c hit on wrong direction");
	a_b_size: assert property (@(posedge clk_sys) disable iff (rst)
		(match[1] && !s_q.ctl_b.tag && s_q.ctl_b.size_chk &&
		$stable(s_q.ctl_b)) |-> $past(bus.byte_acc) == s_q.ctl_b.size_sel)
		else $error("b hit on wrong size");
	a_range_b_off: assert property (@(posedge clk_sys) disable iff (rst)
		(s_q.range[1] && $stable(s_q.range)) |-> !match[1])
		else $error("b channel in range mode");
	a_inv_empty: assert property (@(posedge clk_sys) disable iff (rst)
		($past(s_q.ctl_a.invert) && $past(s_q.mask_a) == 16'h0 &&
		!$past(s_q.ctl_a.tag)) |-> !match[0])
		else $error("invert with empty mask matched");
	a_match_pulse: assert property (@(posedge clk_sys) disable iff (rst)
		match[2] && !bus.valid && !tag.tag_hit |=> !match[2])
		else $error("match held without cause");
	a_brk_follows: assert property (@(posedge clk_sys) disable iff (rst)
		brk_req[0] |-> match[0])
		else $error("break without match");
endmodule

// >>> core/bwu_pkg.sv
// package for the bus watch comparator match block
// shared widths, control field positions and range mode codes
package bwu_pkg;
	localparam int ADDR_W = 18;
	localparam int DATA_W = 16;
	// range control codes
	localparam logic [1:0] RANGE_OFF     = 2'h0;
	localparam logic [1:0] RANGE_INSIDE  = 2'h2;
	localparam logic [1:0] RANGE_OUTSIDE = 2'h3;
	// size select encodings
	localparam logic SIZE_WORD = 1'h0;
	localparam logic SIZE_BYTE = 1'h1;
	// direction select encodings
	localparam logic DIR_WRITE = 1'h0;
	localparam logic DIR_READ  = 1'h1;
	// register byte offsets
	localparam logic [5:0] OFS_A_ADDR = 6'h00;
	localparam logic [5:0] OFS_B_ADDR = 6'h04;
	localparam logic [5:0] OFS_C_ADDR = 6'h08;
	localparam logic [5:0] OFS_A_DATA = 6'h0C;
	localparam logic [5:0] OFS_A_MASK = 6'h10;
	localparam logic [5:0] OFS_CTRL   = 6'h14;
	localparam logic [5:0] OFS_STAT   = 6'h18;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// per comparator control bits
	typedef struct packed {
		logic enable;
		logic breakpoint_request_enable;
		logic tag;
		logic invert;
		logic size_chk;
		logic size_sel;
		logic dir_chk;
		logic dir_sel;
	} bwu_ctl_type;
	// one observed cpu bus cycle
	typedef struct packed {
		logic              valid;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              rd;
		logic              byte_acc;
		logic              background_debug_mode;
	} bwu_bus_type;
	typedef struct packed {
		logic              tag_hit;
		logic [ADDR_W-1:0] tag_addr;
	} bwu_tag_type;
	// all state of the top module
	typedef struct packed {
		logic [ADDR_W-1:0] addr_a;
		logic [ADDR_W-1:0] addr_b;
		logic [ADDR_W-1:0] addr_c;
		logic [DATA_W-1:0] data_a;
		logic [DATA_W-1:0] mask_a;
		bwu_ctl_type       ctl_a;
		bwu_ctl_type       ctl_b;
		bwu_ctl_type       ctl_c;
		logic [1:0]        range;
		logic [2:0]        match;
		logic [2:0]        breakpoint_request_enable;
		logic [2:0]        seen;
		logic              aw_ok;
		logic              w_ok;
		logic [5:0]        aw_addr;
		logic [31:0]       w_data;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} bwu_state_type;
endpackage

// >>> tb/bwu_cpu_model.sv
// cpu bus and opcode tracking model facing the bus watch block
// assumes clk_sys from the bench; tasks are called hierarchically
`timescale 1ns/10ps
module bwu_cpu_model
	import bwu_pkg::*;
(
	// clock
	input  wire logic clk_sys,
	// observed bus and tag outputs
	output bwu_bus_type bus,
	output bwu_tag_type tag
);
	// idle bus and tag at time zero
	initial begin
		bus = '0;
		tag = '0;
	end
	// one bus cycle; released lines then show inverted values, except background_debug_mode, which goes low
	task automatic cycle(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d, input logic rd, by, background_debug_mode);
		@(posedge clk_sys);
		bus <= '{1'b1, a, d, rd, by, background_debug_mode};
		@(posedge clk_sys);
		bus <= '{1'b0, ~a, ~d, ~rd, ~by, 1'b0};
	endtask
	// tagged opcode reaches execute for one cycle
	task automatic hit(input logic [ADDR_W-1:0] a);
		@(posedge clk_sys);
		tag <= '{1'b1, a};
		@(posedge clk_sys);
		tag <= '{1'b0, ~a};
	endtask
endmodule

// >>> tb/bwu_match_bench.sv
// self-checking bench for the bus watch comparator match block
// assumes the cpu model for bus traffic and an axi4-lite master here
`timescale 1ns/10ps
`define CHK(nm, e, s) begin total_checks++; if ((e) !== (s)) begin \
fail_count++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module bwu_match_bench
	import bwu_pkg::*;
;
	logic clk_sys, rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [5:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, r;
	logic [1:0] s_bresp, s_rresp;
	logic [2:0] match, brk_req;
	bwu_bus_type bus;
	bwu_tag_type tag;
	int seed, k, fail_count, total_checks;
	logic [17:0] a;
	logic e;
	logic [17:0] a_tab [4] = '{18'h2FF, 18'h300, 18'h310, 18'h311};
	bwu_match bwu_match_inst (.clk_sys(clk_sys), .rst(rst), .bus(bus),
		.tag(tag), .match(match), .brk_req(brk_req),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata),
		.s_wstrb(4'hF), .s_bvalid(s_bvalid), .s_bresp(s_bresp),
		.s_bready(s_bready), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_araddr(s_araddr), .s_rvalid(s_rvalid), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rready(s_rready));
	bwu_cpu_model bwu_cpu_model_inst (.clk_sys(clk_sys), .bus(bus),
		.tag(tag));
	// expected range verdict for window 300..310
	function automatic logic exp_rng(input logic out, input logic [17:0] x);
		exp_rng = out ? (x < 18'h300 || x > 18'h310) :
			(x >= 18'h300 && x <= 18'h310);
	endfunction
	// expected comparator c verdict at address 155
	function automatic logic exp_c(input logic [17:0] x, input logic [31:0] v,
		input logic [1:0] dc);
		exp_c = x == 18'h155 && !(v[18] & v[19]) && (!dc[1] || v[16] == dc[0]);
	endfunction
	// verdict and end of run
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// register write, address and data offered together
	task automatic wreg(input logic [5:0] ad, input logic [31:0] d,
		input logic [1:0] er);
		int n;
		@(posedge clk_sys);
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_awaddr <= ad;
		s_wdata <= d;
		s_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
			n++;
		end while (s_bvalid !== 1'b1 && n < 50);
		s_bready <= 1'b0;
		if (s_bvalid !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
		`CHK("bresp", er, s_bresp)
	endtask
	// register read with expected data and response
	task automatic rreg(input logic [5:0] ad, input logic [31:0] ed,
		input logic [1:0] er);
		int n;
		@(posedge clk_sys);
		s_arvalid <= 1'b1;
		s_araddr <= ad;
		s_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			if (s_arready) s_arvalid <= 1'b0;
			n++;
		end while (s_rvalid !== 1'b1 && n < 50);
		s_rready <= 1'b0;
		if (s_rvalid !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
		`CHK("rdata", ed, s_rdata)
		`CHK("rresp", er, s_rresp)
	endtask
	// control word: range code and three comparator bytes
	task automatic ctl(input logic [1:0] rg, input logic [7:0] ca, cb, cc);
		wreg(OFS_CTRL, {6'h00, rg, cc, cb, ca}, RESP_OKAY);
	endtask
	// one bus cycle, then masked match channels compared
	task automatic go(input logic [17:0] x, input logic [15:0] d,
		input logic rw, by, bd, input logic [2:0] m, ex);
		bwu_cpu_model_inst.cycle(x, d, rw, by, bd);
		#1;
		`CHK("match", ex, match & m)
	endtask
	// free running clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// main sequence
	initial begin
		{rst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 6'h20;
		{s_awaddr, s_araddr, s_wdata} = '0;
		seed = 32'h2284;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		rreg(OFS_CTRL, 32'h0, RESP_OKAY);
		rreg(6'h1C, 32'h0, RESP_SLVERR);
		wreg(6'h1C, 32'hFFFFFFFF, RESP_SLVERR);
		// comparator c against random cycles around its address
		wreg(OFS_C_ADDR, 32'h155, RESP_OKAY);
		for (k = 0; k < 4; k++) begin
			ctl(RANGE_OFF, 8'h00, 8'h00, {6'b110000, k[1:0]});
			repeat (12) begin
				a = 18'h154 + 18'($unsigned($random(seed)) % 3);
				r = $random(seed);
				bwu_cpu_model_inst.cycle(a, r[15:0], r[16], r[17],
					r[18] & r[19]);
				#1;
				e = exp_c(a, r, k[1:0]);
				`CHK("match_c", e, match[2])
				`CHK("brk_c", e, brk_req[2])
			end
		end
		// comparator b size qualification
		wreg(OFS_B_ADDR, 32'h100, RESP_OKAY);
		ctl(RANGE_OFF, 8'h00, 8'h8C, 8'h00);
		go(18'h100, 16'h0, 1'b1, 1'b0, 1'b0, 3'h2, 3'h0);
		go(18'h100, 16'h0, 1'b1, 1'b1, 1'b0, 3'h2, 3'h2);
		ctl(RANGE_OFF, 8'h00, 8'h88, 8'h00);
		go(18'h100, 16'h0, 1'b0, 1'b0, 1'b0, 3'h2, 3'h2);
		go(18'h100, 16'h0, 1'b0, 1'b1, 1'b0, 3'h2, 3'h0);
		// comparator a data with upper mask half
		wreg(OFS_A_ADDR, 32'h200, RESP_OKAY);
		wreg(OFS_A_DATA, 32'hAB00, RESP_OKAY);
		wreg(OFS_A_MASK, 32'hFF00, RESP_OKAY);
		ctl(RANGE_OFF, 8'h80, 8'h00, 8'h00);
		go(18'h200, 16'hAB12, 1'b0, 1'b0, 1'b0, 3'h1, 3'h1);
		go(18'h200, 16'h12AB, 1'b0, 1'b0, 1'b0, 3'h1, 3'h0);
		ctl(RANGE_OFF, 8'h90, 8'h00, 8'h00);
		go(18'h200, 16'h12AB, 1'b0, 1'b0, 1'b0, 3'h1, 3'h1);
		go(18'h200, 16'hAB12, 1'b0, 1'b0, 1'b0, 3'h1, 3'h0);
		wreg(OFS_A_MASK, 32'h0, RESP_OKAY);
		go(18'h200, 16'hAB12, 1'b0, 1'b0, 1'b0, 3'h1, 3'h0);
		ctl(RANGE_OFF, 8'h80, 8'h00, 8'h00);
		go(18'h200, 16'h5A5A, 1'b0, 1'b0, 1'b0, 3'h1, 3'h1);
		// range pair, b size bits set but ignored
		wreg(OFS_A_ADDR, 32'h300, RESP_OKAY);
		wreg(OFS_B_ADDR, 32'h310, RESP_OKAY);
		for (k = 0; k < 2; k++) begin
			ctl(k ? RANGE_OUTSIDE : RANGE_INSIDE, 8'h83, 8'h8C, 8'h00);
			foreach (a_tab[i]) begin
				e = exp_rng(k[0], a_tab[i]);
				go(a_tab[i], 16'h0, 1'b1, 1'b0, 1'b0, 3'h1,
					{2'h0, e});
			end
			// a's direction bits refuse a write inside the window
			go(18'h300, 16'h0, 1'b0, 1'b0, 1'b0, 3'h1, 3'h0);
		end
		// tag mode on c: a bus write is silent, execution hits
		wreg(OFS_C_ADDR, 32'h190, RESP_OKAY);
		// forced: even address catches the fetch of an opcode at 191
		ctl(RANGE_OFF, 8'h00, 8'h00, 8'h80);
		go(18'h190, 16'h0, 1'b1, 1'b0, 1'b0, 3'h4, 3'h4);
		ctl(RANGE_OFF, 8'h00, 8'h00, 8'hA3);
		go(18'h190, 16'h0, 1'b0, 1'b0, 1'b0, 3'h4, 3'h0);
		bwu_cpu_model_inst.hit(18'h190);
		#1;
		`CHK("tag_hit", 3'h4, match)
		bwu_cpu_model_inst.hit(18'h191);
		#1;
		`CHK("tag_miss", 3'h0, match)
		// tagged inside range 300..310 at word granularity, b bits unused
		ctl(RANGE_INSIDE, 8'hE0, 8'hCC, 8'h00);
		bwu_cpu_model_inst.hit(18'h311);
		#1;
		`CHK("rng_tag_in", 3'h1, match)
		`CHK("rng_brk", 3'h1, brk_req)
		bwu_cpu_model_inst.hit(18'h2FF);
		#1;
		`CHK("rng_tag_out", 3'h0, match)
		ctl(RANGE_OFF, 8'h00, 8'h00, 8'h00);
		// sticky seen bits of all three channels, then cleared
		rreg(OFS_STAT, 32'h38, RESP_OKAY);
		wreg(OFS_STAT, 32'h38, RESP_OKAY);
		rreg(OFS_STAT, 32'h0, RESP_OKAY);
		give_verdict();
	end
endmodule
